// ==== acc_defs.svh ====
// Functional notes
// - continuous mode repeats conversion of selected channel, each result overwrites the last.
// - continuous mode keeps start bit set until cleared or mode off and conversion ends.
// - outside continuous mode the start bit clears itself when the conversion ends.
// - while compare is enabled, each 10-bit result is compared with the 10-bit reference into compare output.
// - compare output is refreshed from every new conversion result while compare is enabled, else it holds.
// - a change of compare output sets the compare change flag.
// - compare change requests an interrupt only if its enable was already set.
// - reference upper eight bits in high byte, lowest two in low register bits 7-6.
// - reference writes are taken only while compare is disabled.
// - each conversion takes 34 converter clock cycles.
// - done flag is set at the end of every conversion.
// - result upper eight bits in result high byte, low two in control bits 7-6.
// - start requests during a conversion in progress are ignored.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// register byte offsets
`define ACC_OFF_CTRL 8'h00
`define ACC_OFF_RES_HI 8'h04
`define ACC_OFF_REF_HI 8'h08
`define ACC_OFF_REF_LO 8'h0C
`define ACC_OFF_CMP 8'h10
`define ACC_OFF_CONT 8'h14
`define ACC_OFF_STAT 8'h18
`define ACC_OFF_MASK 8'h1C

// converter_control fields
`define ACC_CTRL_CH_LSB 0
`define ACC_CTRL_CH_MSB 2
`define ACC_CTRL_START 3
`define ACC_CTRL_DONE 4
`define ACC_CTRL_EXT 5
`define ACC_CTRL_RES0 6
`define ACC_CTRL_RES1 7

// reference low register field
`define ACC_REF_LO_LSB 6
`define ACC_REF_LO_MSB 7

// compare control fields
`define ACC_CMP_EN 0
`define ACC_CMP_IRQ_EN 1
`define ACC_CMP_OUT 2
`define ACC_CMP_CHG 3

// continuous control field
`define ACC_CONT_EN 0

// interrupt status and mask bits
`define ACC_IRQ_DONE 0
`define ACC_IRQ_CMP 1

// reset values
`define ACC_RST_BYTE 8'h00
`define ACC_RST_REF 10'h000
`define ACC_RST_IRQ 2'h0

// conversion length in converter clock cycles
`define ACC_CONV_CYCLES 6'h22
`define ACC_CONV_LAST (`ACC_CONV_CYCLES - 6'h01)

`endif

// ==== acc_pkg.sv ====
package acc_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } acc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } acc_wb_rsp_t;

  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
  } acc_tmr_state_t;

  typedef struct packed {
    logic [2:0] chan;
    logic start;
    logic done_flag;
    logic ext_en;
    logic ext_prev;
    logic cont;
    logic [9:0] result;
    logic [9:0] cmp_ref;
    logic cmp_en;
    logic cmp_irq_en;
    logic cmp_out;
    logic chg_flag;
    logic [1:0] status;
    logic [1:0] mask;
    logic ack;
    logic [31:0] dat;
  } acc_state_t;

endpackage

// ==== acc_conv_timer.sv ====
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_conv_timer import acc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  acc_tmr_state_t t_r;
  acc_tmr_state_t t_nxt;

  assign busy_o = t_r.busy;
  assign done_o = t_r.busy && (t_r.cnt == `ACC_CONV_LAST);

  always_comb begin
    t_nxt = t_r;
    if (t_r.busy) begin
      // a start while busy has no effect
      if (done_o) begin
        t_nxt.busy = 1'b0;
        t_nxt.cnt = 6'h00;
      end else begin
        t_nxt.cnt = t_r.cnt + 6'h01;
      end
    end else if (start_i) begin
      t_nxt.busy = 1'b1;
      t_nxt.cnt = 6'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  a_conv_len_34: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_o) |-> ##33 done_o)
    else $error("conversion did not end after 34 cycles");

  a_done_ends_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |=> !busy_o)
    else $error("busy still high after done");

  a_busy_no_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o && !done_o |=> busy_o && (t_r.cnt == $past(t_r.cnt) + 6'h01))
    else $error("conversion disturbed while in progress");

endmodule

// ==== acc_top.sv ====
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_top import acc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire acc_wb_req_t wb_req_i,
  output acc_wb_rsp_t wb_rsp_o,
  input wire logic [9:0] sample_i,
  input wire logic ext_start_i,
  output logic [2:0] channel_o,
  output logic conv_busy_o,
  output logic irq_o
);

  acc_state_t s_r;
  acc_state_t s_nxt;

  logic req;
  logic wr;
  logic rd;
  logic [7:0] wd;
  logic [7:0] rbyte;
  logic ext_edge;
  logic take;
  logic tmr_busy;
  logic conv_done;
  logic new_cmp;
  logic cmp_chg;
  logic ctrl_wr;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  acc_conv_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(take),
    .busy_o(tmr_busy),
    .done_o(conv_done)
  );

  assign ext_edge = ext_start_i && !s_r.ext_prev;
  assign take = !tmr_busy && (s_r.start || (ext_edge && s_r.ext_en));
  assign new_cmp = (sample_i >= s_r.cmp_ref);
  assign cmp_chg = conv_done && s_r.cmp_en && (new_cmp != s_r.cmp_out);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign req = wb_req_i.cyc && wb_req_i.stb && !s_r.ack;
  assign wr = req && wb_req_i.we && wb_req_i.sel[0];
  assign rd = req && !wb_req_i.we;
  assign wd = wb_req_i.dat[7:0];
  assign ctrl_wr = wr && (wb_req_i.adr == `ACC_OFF_CTRL);

  always_comb begin
    rbyte = 8'h00;
    if (wb_req_i.adr == `ACC_OFF_CTRL) begin
      rbyte = {s_r.result[1:0], s_r.ext_en, s_r.done_flag, s_r.start, s_r.chan};
    end else if (wb_req_i.adr == `ACC_OFF_RES_HI) begin
      rbyte = s_r.result[9:2];
    end else if (wb_req_i.adr == `ACC_OFF_REF_HI) begin
      rbyte = s_r.cmp_ref[9:2];
    end else if (wb_req_i.adr == `ACC_OFF_REF_LO) begin
      rbyte = {s_r.cmp_ref[1:0], 6'h00};
    end else if (wb_req_i.adr == `ACC_OFF_CMP) begin
      rbyte = {4'h0, s_r.chg_flag, s_r.cmp_out, s_r.cmp_irq_en, s_r.cmp_en};
    end else if (wb_req_i.adr == `ACC_OFF_CONT) begin
      rbyte = {7'h00, s_r.cont};
    end else if (wb_req_i.adr == `ACC_OFF_STAT) begin
      rbyte = {6'h00, s_r.status};
    end else if (wb_req_i.adr == `ACC_OFF_MASK) begin
      rbyte = {6'h00, s_r.mask};
    end else begin
      rbyte = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state update

  always_comb begin
    s_nxt = s_r;
    s_nxt.ext_prev = ext_start_i;
    s_nxt.ack = req;
    if (rd) begin
      s_nxt.dat = {24'h000000, rbyte};
    end

    // end of conversion
    if (conv_done) begin
      s_nxt.result = sample_i;
      if (!s_r.cont) begin
        s_nxt.start = 1'b0;
      end
      if (s_r.cmp_en) begin
        s_nxt.cmp_out = new_cmp;
      end
    end
    if (take) begin
      s_nxt.start = 1'b1;
    end

    // software writes
    if (ctrl_wr) begin
      s_nxt.chan = wd[`ACC_CTRL_CH_MSB:`ACC_CTRL_CH_LSB];
      s_nxt.start = wd[`ACC_CTRL_START];
      s_nxt.ext_en = wd[`ACC_CTRL_EXT];
      if (!wd[`ACC_CTRL_DONE]) begin
        s_nxt.done_flag = 1'b0;
      end
    end
    if (wr && (wb_req_i.adr == `ACC_OFF_REF_HI) && !s_r.cmp_en) begin
      s_nxt.cmp_ref[9:2] = wd;
    end
    if (wr && (wb_req_i.adr == `ACC_OFF_REF_LO) && !s_r.cmp_en) begin
      s_nxt.cmp_ref[1:0] = wd[`ACC_REF_LO_MSB:`ACC_REF_LO_LSB];
    end
    if (wr && (wb_req_i.adr == `ACC_OFF_CMP)) begin
      s_nxt.cmp_en = wd[`ACC_CMP_EN];
      s_nxt.cmp_irq_en = wd[`ACC_CMP_IRQ_EN];
      if (wd[`ACC_CMP_CHG]) begin
        s_nxt.chg_flag = 1'b0;
      end
    end
    if (wr && (wb_req_i.adr == `ACC_OFF_CONT)) begin
      s_nxt.cont = wd[`ACC_CONT_EN];
    end
    if (wr && (wb_req_i.adr == `ACC_OFF_MASK)) begin
      s_nxt.mask = wd[1:0];
    end
    if (rd && (wb_req_i.adr == `ACC_OFF_STAT)) begin
      s_nxt.status = `ACC_RST_IRQ;
    end

    // hardware sets last so they win over a clear in the same cycle
    if (conv_done) begin
      s_nxt.done_flag = 1'b1;
      s_nxt.status[`ACC_IRQ_DONE] = 1'b1;
    end
    if (cmp_chg) begin
      s_nxt.chg_flag = 1'b1;
      if (s_r.cmp_irq_en) begin
        s_nxt.status[`ACC_IRQ_CMP] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.result <= `ACC_RST_REF;
      s_r.cmp_ref <= `ACC_RST_REF;
      s_r.mask <= `ACC_RST_IRQ;
      s_r.status <= `ACC_RST_IRQ;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_rsp_o.ack = s_r.ack;
  assign wb_rsp_o.dat = s_r.dat;
  assign channel_o = s_r.chan;
  assign conv_busy_o = tmr_busy;
  assign irq_o = |(s_r.status & s_r.mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_single_start_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done && !s_r.cont && !ctrl_wr |=> !s_r.start)
    else $error("start bit not cleared after single conversion");

  a_cont_start_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done && s_r.cont && s_r.start && !ctrl_wr |=> s_r.start)
    else $error("start bit dropped in continuous mode");

  a_cont_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_done && s_r.cont && s_r.start && !ctrl_wr) ##1 !ctrl_wr |=> tmr_busy)
    else $error("continuous mode did not restart conversion");

  a_done_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done |=> s_r.done_flag && s_r.status[`ACC_IRQ_DONE])
    else $error("done flag not set at conversion end");

  a_result_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done |=> s_r.result == $past(sample_i))
    else $error("result not captured at conversion end");

  a_cmp_update: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done && s_r.cmp_en |=> s_r.cmp_out == ($past(sample_i) >= s_r.cmp_ref))
    else $error("compare output does not match result");

  a_cmp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(conv_done && s_r.cmp_en) |=> $stable(s_r.cmp_out))
    else $error("compare output changed without evaluation");

  a_chg_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_done && s_r.cmp_en && (new_cmp != s_r.cmp_out) |=> s_r.chg_flag)
    else $error("change flag not set on compare change");

  a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_chg && !s_r.cmp_irq_en && !s_r.status[`ACC_IRQ_CMP]
    |=> !s_r.status[`ACC_IRQ_CMP])
    else $error("compare interrupt raised while disabled");

  a_irq_raised: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_chg && s_r.cmp_irq_en |=> s_r.status[`ACC_IRQ_CMP])
    else $error("compare interrupt not raised");

  a_ref_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.cmp_en |=> $stable(s_r.cmp_ref))
    else $error("reference changed while compare enabled");

  a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> s_r.ack ##1 !s_r.ack)
    else $error("bus ack not a single cycle after request");

endmodule

// ==== tb_acc_top.sv ====
`timescale 1ns/1ps
module tb_acc_top import acc_pkg::*; ();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  acc_wb_req_t req = '0;
  acc_wb_rsp_t rsp;
  logic [9:0] sample = 10'h000;
  logic ext = 1'b0;
  logic busy;
  logic irq;
  logic [2:0] chan;
  int xen = 0;
  logic [31:0] x = 32'h54DE;
  logic [31:0] rd;
  int errors = 0;
  int n_checks = 0;
  // software view of the block
  int refv = 0;
  int res = 0;
  int out = 0;
  int chg = 0;
  int cen = 0;
  int ien = 0;
  int st = 0;

  always #50 clk_i = ~clk_i;

  acc_top dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .sample_i(sample),
    .ext_start_i(ext),
    .channel_o(chan),
    .conv_busy_o(busy),
    .irq_o(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic hang;
    errors++;
    summarize;
  endtask

  // classic single cycle; released only at the edge where ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (rsp.ack === 1'b1) break;
    end
    if (i == 20) hang;
    rd = rsp.dat;
    req <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd, e);
  endtask

  // one conversion; go writes the start bit, otherwise one already runs
  task automatic conv(input bit go, input bit exp_start, input logic [9:0] s);
    int n;
    int i;
    int o;
    sample <= s;
    if (go) wb(1'b1, 8'h00, 32'h0000000D);
    n = 0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_i);
      if (busy === 1'b1) n++;
      else if (n > 0) break;
    end
    if (i == 200) hang;
    if (go) chk("busy cycles", n, 34);
    res = s;
    st = st | 1;
    if (cen != 0) begin
      o = (res >= refv);
      if (o != out) begin
        chg = 1;
        if (ien != 0) st = st | 2;
      end
      out = o;
    end
    rdc(8'h00, {res[1:0], xen[0], 1'b1, exp_start, 3'h5});
    chk("channel", chan, 3'h5);
    rdc(8'h04, res[9:2]);
    rdc(8'h10, {chg[0], out[0], ien[0], cen[0]});
    chk("irq", irq, (st & 3) != 0);
    rdc(8'h18, st);
    st = 0;
    $display("conversion of %h finished", s);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'hFC, 32'h0);
    chk("irq", irq, 0);
    wb(1'b1, 8'h08, 32'h80);
    wb(1'b1, 8'h0C, 32'hFF);
    refv = 10'h203;
    rdc(8'h08, 32'h80);
    rdc(8'h0C, 32'hC0);
    $display("reset and reference done");
    wb(1'b1, 8'h1C, 32'h3);
    wb(1'b1, 8'h10, 32'h1);
    cen = 1;
    wb(1'b1, 8'h08, 32'h11);
    rdc(8'h08, 32'h80);
    x = xs(x);
    conv(1'b1, 1'b0, {2'b11, x[7:0]});
    wb(1'b1, 8'h10, 32'hB);
    ien = 1;
    chg = 0;
    x = xs(x);
    conv(1'b1, 1'b0, {1'b0, x[8:0]});
    wb(1'b1, 8'h10, 32'h0);
    cen = 0;
    ien = 0;
    conv(1'b1, 1'b0, 10'h3FF);
    wb(1'b1, 8'h10, 32'h1);
    cen = 1;
    wb(1'b1, 8'h14, 32'h1);
    x = xs(x);
    conv(1'b1, 1'b1, x[9:0]);
    x = xs(x);
    conv(1'b0, 1'b1, x[9:0]);
    wb(1'b1, 8'h14, 32'h0);
    x = xs(x);
    conv(1'b0, 1'b0, x[9:0]);
    // external rising edge starts a single conversion when enabled
    wb(1'b1, 8'h00, 32'h00000025);
    xen = 1;
    @(posedge clk_i);
    ext <= 1'b1;
    x = xs(x);
    conv(1'b0, 1'b0, x[9:0]);
    ext <= 1'b0;
    summarize;
  end
endmodule
